// >>> rtl/zpg_pkg.sv
// Shared constants for the zone plate pattern generator
package zpg_pkg;
    // Widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int AMP_W = 11;
    localparam int PH_W = 12;
    localparam int ACC_W = 32;
    localparam int FRAC_W = 28;
    localparam int NUM_COEF = 8;
    localparam int PAT_W = 3;
    // Product shifts for the fixed-point scaling
    localparam int SH_NONE = 0;
    localparam int SH_APH = 24;
    localparam int SH_DT = 16;
    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_AMP = 4'h1;
    localparam logic [ADDR_W-1:0] REG_COEF0 = 4'h2;
    localparam logic [ADDR_W-1:0] REG_COEF_END = 4'hA;
    localparam logic [ADDR_W-1:0] REG_INV_APH = 4'hA;
    localparam logic [ADDR_W-1:0] REG_FRAME_DT = 4'hB;
    localparam logic [ADDR_W-1:0] REG_SEL = 4'hC;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'hD;
    // Control field positions
    localparam int CTRL_PAT_LSB = 0;
    localparam int CTRL_SHAPE_LSB = 3;
    localparam int CTRL_EN_BIT = 5;
    // Status bit positions
    localparam int ST_VALID = 0;
    localparam int ST_PEND = 1;
    localparam int ST_HWRAP = 2;
    localparam int ST_VWRAP = 3;
    // Coefficient slots
    localparam logic [2:0] C_HORIZ_FREQ = 3'h0;
    localparam logic [2:0] C_HORIZ_SWEEP = 3'h1;
    localparam logic [2:0] C_VERT_CHANGE_HORIZ = 3'h2;
    localparam logic [2:0] C_VERT_FREQ = 3'h3;
    localparam logic [2:0] C_VERT_SWEEP = 3'h4;
    localparam logic [2:0] C_PHASE = 3'h5;
    localparam logic [2:0] C_TIME_CHANGE_HORIZ = 3'h6;
    localparam logic [2:0] C_TIME_CHANGE_VERT = 3'h7;
    // Patterns, shapes and menu selections
    localparam logic [PAT_W-1:0] PATTERN_CUSTOM1 = 3'h6;
    localparam logic [1:0] SHAPE_SINE = 2'h0;
    localparam logic [1:0] SHAPE_TRI = 2'h1;
    localparam logic [1:0] SHAPE_SQUARE = 2'h2;
    localparam logic [3:0] SEL_AMP = 4'h0;
    localparam logic [3:0] SEL_SHAPE = 4'h9;
    // Reset values and limits (amplitude in 0.5 mV steps)
    localparam logic [AMP_W-1:0] AMP_MAX = 11'h63C;
    localparam logic [AMP_W-1:0] AMP_DEF = 11'h578;
    localparam logic [DATA_W-1:0] INV_APH_DEF = 16'h3CAE;
    localparam logic [DATA_W-1:0] FRAME_DT_DEF = 16'h0444;
    localparam logic signed [ACC_W-1:0] HALF_CYCLE = 32'sh0800_0000;
    // Quarter-wave sine table, 17 points
    localparam logic [10:0] SIN_TAB [0:16] = '{
        11'h000, 11'h0C9, 11'h18F, 11'h252, 11'h30F, 11'h3C5,
        11'h471, 11'h513, 11'h5A7, 11'h62E, 11'h6A6, 11'h70D,
        11'h763, 11'h7A7, 11'h7D8, 11'h7F5, 11'h7FF};
endpackage

// >>> rtl/zpg_shaper.sv
// Waveform shaping and amplitude scaling of one phase sample
module zpg_shaper import zpg_pkg::*; (
    // Phase and settings
    input wire logic [PH_W-1:0] i_phase,
    input wire logic [1:0] i_shape,
    input wire logic [AMP_W-1:0] i_amp,
    // Scaled level
    output logic [AMP_W-1:0] o_level
);
    logic [4:0] idx;
    logic [10:0] mag;
    logic signed [11:0] wave;
    logic [11:0] offs;
    logic [22:0] prod;

    // Magnitude by quadrant, sign from the upper half cycle
    always_comb begin
        idx = {1'b0, i_phase[9:6]};
        unique case (i_shape)
            SHAPE_TRI: begin
                // Falling quadrant fills the low bit so the peak reaches full scale
                mag = i_phase[10] ? {~i_phase[9:0], 1'b1} : {i_phase[9:0], 1'b0};
            end
            SHAPE_SQUARE: begin
                mag = SIN_TAB[16];
            end
            default: begin
                mag = i_phase[10] ? SIN_TAB[5'h10 - idx] : SIN_TAB[idx];
            end
        endcase
        wave = i_phase[11] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
        offs = {~wave[11], wave[10:0]}; // Offset binary, black at zero
        prod = 23'(offs) * 23'(i_amp) + 23'h000800;
        o_level = prod[22:12];
    end
endmodule

// >>> rtl/zpg_top.sv
// Zone plate pattern generator with menu parameter handling
//
// The implementer's own choices: the register offsets and the strobed register port.
module zpg_top import zpg_pkg::*; (
    // Clock, reset, enable
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // Register port
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [DATA_W-1:0] O_RDATA,
    // Front panel keys
    input wire logic I_ADJ_LEFT,
    input wire logic I_ADJ_RIGHT,
    input wire logic I_ENTER,
    input wire logic I_CANCEL,
    // Video timing
    input wire logic I_FRAME_START,
    input wire logic I_LINE_START,
    input wire logic I_ACTIVE,
    // Pattern output and menu state
    output logic [AMP_W-1:0] O_LEVEL,
    output logic O_LEVEL_VALID,
    output logic O_CTRL_VALID,
    output logic O_CONFIRM_PENDING
);
    typedef struct packed {
        logic [PAT_W-1:0] pattern;
        logic [1:0] shape;
        logic enable;
        logic [AMP_W-1:0] amp;
        logic [NUM_COEF-1:0][DATA_W-1:0] coef;
        logic [DATA_W-1:0] inv_aph;
        logic [DATA_W-1:0] frame_dt;
        logic [3:0] sel;
        logic ctrl_valid;
        logic pending;
        logic [2:0] pend_idx;
        logic [DATA_W-1:0] pend_val;
        logic hwrap;
        logic vwrap;
        logic [DATA_W-1:0] rdata;
        logic signed [ACC_W-1:0] phase;
        logic signed [ACC_W-1:0] fx;
        logic signed [ACC_W-1:0] ph_row;
        logic signed [ACC_W-1:0] fy;
        logic signed [ACC_W-1:0] fxy;
        logic signed [ACC_W-1:0] fxt;
        logic signed [ACC_W-1:0] fyt;
        logic [AMP_W-1:0] level;
        logic level_valid;
    } zpg_state_type;

    localparam zpg_state_type ZPG_RST = '{amp: AMP_DEF, inv_aph: INV_APH_DEF,
        frame_dt: FRAME_DT_DEF, ctrl_valid: 1'b1, enable: 1'b1, default: '0};

    zpg_state_type q;
    zpg_state_type n;

    // Signed product with a fixed right shift
    function automatic logic signed [ACC_W-1:0] zpg_scale(
        input logic signed [ACC_W-1:0] a, input logic [DATA_W-1:0] b, input int sh);
        logic signed [48:0] p;
        p = a * $signed({1'b0, b});
        zpg_scale = ACC_W'(p >>> sh);
    endfunction

    // Coefficient in c/aph to cycles per sample or line
    function automatic logic signed [ACC_W-1:0] zpg_per_step(
        input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] u);
        zpg_per_step = zpg_scale(ACC_W'($signed(c)), u, SH_NONE);
    endfunction

    // Frequency folded into plus or minus half a cycle
    function automatic logic signed [ACC_W-1:0] zpg_fold(input logic signed [ACC_W-1:0] a);
        zpg_fold = {{(ACC_W-FRAC_W){a[FRAC_W-1]}}, a[FRAC_W-1:0]};
    endfunction

    // Clamp to plus or minus half a cycle
    function automatic logic signed [ACC_W-1:0] zpg_clamp(input logic signed [ACC_W-1:0] a);
        if (a > HALF_CYCLE) begin
            zpg_clamp = HALF_CYCLE;
        end else if (a < -HALF_CYCLE) begin
            zpg_clamp = -HALF_CYCLE;
        end else begin
            zpg_clamp = a;
        end
    endfunction

    logic signed [ACC_W-1:0] kx_lim;
    logic signed [ACC_W-1:0] sx2;
    logic signed [ACC_W-1:0] sxy;
    logic signed [ACC_W-1:0] sy2;
    logic signed [ACC_W-1:0] fy0;
    logic signed [ACC_W-1:0] k_phase;
    logic signed [ACC_W-1:0] fx_start;
    logic signed [ACC_W-1:0] fxt_sum;
    logic signed [ACC_W-1:0] fyt_sum;
    logic signed [ACC_W-1:0] fxt_next;
    logic signed [ACC_W-1:0] fyt_next;
    logic coef_wr;
    logic [2:0] coef_idx;
    logic both_adj;
    logic [AMP_W-1:0] shaped;
    logic [DATA_W-1:0] rd_mux;

    // Per-step increments from the coefficients
    assign kx_lim = zpg_clamp(zpg_per_step(q.coef[C_HORIZ_FREQ], q.inv_aph));
    assign sx2 = zpg_scale(zpg_per_step(q.coef[C_HORIZ_SWEEP], q.inv_aph), q.inv_aph, SH_APH);
    assign sxy = zpg_scale(zpg_per_step(q.coef[C_VERT_CHANGE_HORIZ], q.inv_aph), q.inv_aph, SH_APH);
    assign sy2 = zpg_scale(zpg_per_step(q.coef[C_VERT_SWEEP], q.inv_aph), q.inv_aph, SH_APH);
    assign fy0 = zpg_per_step(q.coef[C_VERT_FREQ], q.inv_aph) + (sy2 >>> 1);
    assign k_phase = {{4{q.coef[C_PHASE][15]}}, q.coef[C_PHASE], 12'h000};
    assign fx_start = kx_lim + (sx2 >>> 1) + q.fxy + q.fxt;

    // Temporal frequency growth, folded at the format maximum
    assign fxt_sum = q.fxt + zpg_scale(zpg_per_step(q.coef[C_TIME_CHANGE_HORIZ], q.inv_aph),
        q.frame_dt, SH_DT);
    assign fyt_sum = q.fyt + zpg_scale(zpg_per_step(q.coef[C_TIME_CHANGE_VERT], q.inv_aph),
        q.frame_dt, SH_DT);
    assign fxt_next = zpg_fold(fxt_sum);
    assign fyt_next = zpg_fold(fyt_sum);

    // Register port decode
    assign coef_wr = I_WR && (I_ADDR >= REG_COEF0) && (I_ADDR < REG_COEF_END);
    assign coef_idx = 3'(I_ADDR - REG_COEF0);
    assign both_adj = I_ADJ_LEFT && I_ADJ_RIGHT;

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        if ((I_ADDR >= REG_COEF0) && (I_ADDR < REG_COEF_END)) begin
            rd_mux = q.coef[3'(I_ADDR - REG_COEF0)];
        end else begin
            unique case (I_ADDR)
                REG_CTRL: rd_mux = DATA_W'({q.enable, q.shape, q.pattern});
                REG_AMP: rd_mux = DATA_W'(q.amp);
                REG_INV_APH: rd_mux = q.inv_aph;
                REG_FRAME_DT: rd_mux = q.frame_dt;
                REG_SEL: rd_mux = DATA_W'(q.sel);
                REG_STATUS: rd_mux = DATA_W'({q.vwrap, q.hwrap, q.pending, q.ctrl_valid});
                default: rd_mux = '0;
            endcase
        end
    end

    // Waveform of the current phase
    zpg_shaper zpg_shaper_inst (
        .i_phase(q.phase[FRAC_W-1 -: PH_W]),
        .i_shape(q.shape),
        .i_amp(q.amp),
        .o_level(shaped)
    );

    // Next state
    always_comb begin
        n = q;
        n.rdata = I_RD ? rd_mux : '0;
        // Confirmation prompt answers
        if (q.pending && I_ENTER) begin
            n.coef[q.pend_idx] = q.pend_val;
            n.ctrl_valid = 1'b0;
            n.pending = 1'b0;
        end else if (q.pending && I_CANCEL) begin
            n.pending = 1'b0;
        end
        // Both adjust keys restore the selected default
        if (both_adj) begin
            if (q.sel == SEL_AMP) begin
                n.amp = AMP_DEF;
            end else if (q.sel == SEL_SHAPE) begin
                n.shape = SHAPE_SINE;
            end else if (q.sel < SEL_SHAPE) begin
                n.coef[3'(q.sel - 4'h1)] = '0;
            end
        end
        // Software writes
        if (coef_wr) begin
            if (n.ctrl_valid) begin
                n.pending = 1'b1;
                n.pend_idx = coef_idx;
                n.pend_val = I_WDATA;
            end else begin
                n.coef[coef_idx] = I_WDATA;
            end
        end else if (I_WR) begin
            unique case (I_ADDR)
                REG_CTRL: begin
                    n.pattern = I_WDATA[CTRL_PAT_LSB +: PAT_W];
                    n.shape = I_WDATA[CTRL_SHAPE_LSB +: 2];
                    n.enable = I_WDATA[CTRL_EN_BIT];
                    n.ctrl_valid = I_WDATA[CTRL_PAT_LSB +: PAT_W] < PATTERN_CUSTOM1;
                    n.pending = 1'b0;
                end
                REG_AMP: begin
                    n.amp = (I_WDATA > DATA_W'(AMP_MAX)) ? AMP_MAX : I_WDATA[AMP_W-1:0];
                end
                REG_INV_APH: n.inv_aph = I_WDATA;
                REG_FRAME_DT: n.frame_dt = I_WDATA;
                REG_SEL: n.sel = I_WDATA[3:0];
                REG_STATUS: begin
                    if (I_WDATA[ST_HWRAP]) begin
                        n.hwrap = 1'b0;
                    end
                    if (I_WDATA[ST_VWRAP]) begin
                        n.vwrap = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Output sample from the current phase
        n.level_valid = I_ACTIVE && q.enable;
        n.level = (I_ACTIVE && q.enable) ? shaped : '0;
        // Phase accumulators
        if (I_FRAME_START) begin
            n.fxt = fxt_next;
            n.fyt = fyt_next;
            if (fxt_next != fxt_sum) begin
                n.hwrap = 1'b1;
            end
            if (fyt_next != fyt_sum) begin
                n.vwrap = 1'b1;
            end
            n.ph_row = k_phase;
            n.fy = fy0 + fyt_next;
            n.fxy = '0;
        end else if (I_LINE_START) begin
            n.phase = q.ph_row;
            n.fx = fx_start;
            n.ph_row = q.ph_row + q.fy;
            n.fy = q.fy + sy2;
            n.fxy = q.fxy + sxy;
        end else if (I_ACTIVE) begin
            n.phase = q.phase + q.fx;
            n.fx = q.fx + sx2;
        end
    end

    // State register, frozen while the enable is low
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            q <= ZPG_RST;
        end else if (I_CE) begin
            q <= n;
        end
    end

    // Outputs
    assign O_RDATA = q.rdata;
    assign O_LEVEL = q.level;
    assign O_LEVEL_VALID = q.level_valid;
    assign O_CTRL_VALID = q.ctrl_valid;
    assign O_CONFIRM_PENDING = q.pending;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_prompt;
        I_CE && coef_wr && q.ctrl_valid && !q.pending && !both_adj;
    endsequence

    sequence s_confirm;
        I_CE && q.pending && I_ENTER && !I_WR && !both_adj;
    endsequence

    property p_amp_write;
        I_CE && I_WR && (I_ADDR == REG_AMP) |=>
            q.amp == (($past(I_WDATA) > DATA_W'(AMP_MAX)) ? AMP_MAX : AMP_W'($past(I_WDATA)));
    endproperty
    a_amp_write: assert property (p_amp_write) else $error("amplitude write not clamped");

    property p_custom;
        q.pattern >= PATTERN_CUSTOM1 |-> !q.ctrl_valid;
    endproperty
    a_custom: assert property (p_custom) else $error("custom pattern has a control parameter");

    property p_prompt;
        s_prompt |=> q.pending && q.ctrl_valid && (q.coef == $past(q.coef));
    endproperty
    a_prompt: assert property (p_prompt) else $error("coefficient applied without prompt");

    property p_confirm;
        s_confirm |=> !q.ctrl_valid && !q.pending && (q.coef[$past(q.pend_idx)] == $past(q.pend_val));
    endproperty
    a_confirm: assert property (p_confirm) else $error("confirm did not apply change");

    property p_default;
        I_CE && both_adj && (q.sel == SEL_AMP) && !I_WR |=> q.amp == AMP_DEF;
    endproperty
    a_default: assert property (p_default) else $error("amplitude not restored");

    property p_hlimit;
        I_CE && I_LINE_START && !I_FRAME_START && (sx2 == '0) && (q.fxy == '0) && (q.fxt == '0)
            |=> (q.fx <= HALF_CYCLE) && (q.fx >= -HALF_CYCLE);
    endproperty
    a_hlimit: assert property (p_hlimit) else $error("horizontal frequency above limit");

    property p_white;
        I_CE && I_ACTIVE && q.enable && (q.shape == SHAPE_SINE) && (q.phase[FRAC_W-1 -: PH_W] == 12'h400)
            |=> q.level == $past(q.amp);
    endproperty
    a_white: assert property (p_white) else $error("quarter phase not white");

    property p_hwrap;
        I_CE && I_FRAME_START && (fxt_next != fxt_sum) |=> q.hwrap ##1 (q.hwrap || $past(I_WR));
    endproperty
    a_hwrap: assert property (p_hwrap) else $error("horizontal wrap not flagged");

    property p_line;
        I_CE && I_LINE_START && !I_FRAME_START |=> (q.phase == $past(q.ph_row)) && (q.fx == $past(fx_start));
    endproperty
    a_line: assert property (p_line) else $error("line start phase wrong");

    property p_square;
        I_CE && I_ACTIVE && q.enable && (q.shape == SHAPE_SQUARE) |=> (q.level == '0) || (q.level == $past(q.amp));
    endproperty
    a_square: assert property (p_square) else $error("square level not black or white");

    property p_sample;
        I_CE && I_ACTIVE && !I_LINE_START && !I_FRAME_START |=> q.phase == ($past(q.phase) + $past(q.fx));
    endproperty
    a_sample: assert property (p_sample) else $error("sample phase step wrong");
endmodule

// >>> testbench/zpg_top_tb.sv
// Self-checking bench for the zone plate pattern generator
module zpg_top_tb import zpg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic adj_l = 1'b0, adj_r = 1'b0, enter = 1'b0, cancel = 1'b0;
    logic fs = 1'b0, ls = 1'b0, act = 1'b0, rd_seen = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [AMP_W-1:0] level, mon_sample;
    logic level_valid, ctrl_valid, pending, mon_stb;
    logic [15:0] mon_count, cnt0, v;
    logic [DATA_W-1:0] rd_q[$];
    logic [AMP_W-1:0] lvl_q[$];
    int failures = 0, n_checks = 0;

    zpg_top zpg_top_inst (.I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ADJ_LEFT(adj_l), .I_ADJ_RIGHT(adj_r),
        .I_ENTER(enter), .I_CANCEL(cancel), .I_FRAME_START(fs), .I_LINE_START(ls), .I_ACTIVE(act),
        .O_LEVEL(level), .O_LEVEL_VALID(level_valid), .O_CTRL_VALID(ctrl_valid),
        .O_CONFIRM_PENDING(pending));
    zpg_wave_monitor zpg_wave_monitor_inst (.i_clk(clk), .i_rst(rst), .i_level(level),
        .i_valid(level_valid), .o_sample(mon_sample), .o_stb(mon_stb), .o_count(mon_count));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim;
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register port cycles
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        rd_q.push_back(exp);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Key presses: both adjust keys, or one confirm/abort pulse
    task automatic press(input logic both, input logic ent, input logic can);
        @(posedge clk);
        adj_l <= both;
        adj_r <= both;
        enter <= ent;
        cancel <= can;
        @(posedge clk);
        {adj_l, adj_r, enter, cancel} <= 4'h0;
        @(negedge clk);
    endtask

    task automatic flags(input logic exp_valid, input logic exp_pend);
        @(negedge clk);
        check({15'h0000, ctrl_valid}, {15'h0000, exp_valid});
        check({15'h0000, pending}, {15'h0000, exp_pend});
    endtask

    // One active line of n samples; expect a level per sample when enabled
    task automatic line(input int n, input logic en, input logic [AMP_W-1:0] exp_even,
        input logic [AMP_W-1:0] exp_odd);
        int k;
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        ls <= 1'b1;
        @(posedge clk);
        ls <= 1'b0;
        act <= 1'b1;
        for (k = 0; k < n; k++) begin
            if (en) lvl_q.push_back(k[0] ? exp_odd : exp_even);
            @(posedge clk);
        end
        act <= 1'b0;
        for (k = 0; k < 20 && lvl_q.size() > 0; k++) @(posedge clk);
        if (lvl_q.size() > 0) begin
            failures++;
            end_sim();
        end
    endtask

    // Result watcher: read data and captured samples against the oldest note
    always @(posedge clk) begin
        if (rd_seen) check(rdata, rd_q.pop_front());
        rd_seen <= rd;
        if (mon_stb) begin
            if (lvl_q.size() == 0) check(16'hFFFF, 16'h0000);
            else check({5'h00, mon_sample}, {5'h00, lvl_q.pop_front()});
        end
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial begin
        logic [AMP_W-1:0] amp;
        int i;
        void'($urandom(32'hEF2A));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped indices
        rd_reg(REG_CTRL, 16'h0020);
        rd_reg(REG_AMP, {5'h00, AMP_DEF});
        rd_reg(REG_INV_APH, INV_APH_DEF);
        rd_reg(REG_FRAME_DT, FRAME_DT_DEF);
        rd_reg(REG_STATUS, 16'h0001);
        rd_reg(4'hE, 16'h0000);
        rd_reg(4'hF, 16'h0000);
        for (i = 0; i < NUM_COEF; i++) rd_reg(REG_COEF0 + 4'(i), 16'h0000);
        // Amplitude limit, then restore of the default
        wr_reg(REG_AMP, 16'h07FF);
        rd_reg(REG_AMP, {5'h00, AMP_MAX});
        wr_reg(REG_AMP, 16'h0000);
        rd_reg(REG_AMP, 16'h0000);
        wr_reg(REG_SEL, {12'h000, SEL_AMP});
        press(1'b1, 1'b0, 1'b0);
        rd_reg(REG_AMP, {5'h00, AMP_DEF});
        // Clock enable low: the write is not taken
        ce <= 1'b0;
        wr_reg(REG_AMP, 16'h0123);
        ce <= 1'b1;
        rd_reg(REG_AMP, {5'h00, AMP_DEF});
        // Coefficient change prompts; abort, then confirm
        wr_reg(REG_COEF0, 16'h0090);
        flags(1'b1, 1'b1);
        rd_reg(REG_COEF0, 16'h0000);
        rd_reg(REG_STATUS, 16'h0003);
        press(1'b0, 1'b0, 1'b1);
        flags(1'b1, 1'b0);
        rd_reg(REG_COEF0, 16'h0000);
        wr_reg(REG_COEF0, 16'h0090);
        press(1'b0, 1'b1, 1'b0);
        flags(1'b0, 1'b0);
        rd_reg(REG_COEF0, 16'h0090);
        rd_reg(REG_STATUS, 16'h0000);
        // Standard pattern restores validity; custom has none
        wr_reg(REG_CTRL, 16'h0020);
        flags(1'b1, 1'b0);
        wr_reg(REG_CTRL, 16'h0026);
        flags(1'b0, 1'b0);
        wr_reg(REG_COEF0 + 4'(C_VERT_FREQ), 16'h1234);
        flags(1'b0, 1'b0);
        rd_reg(REG_COEF0 + 4'(C_VERT_FREQ), 16'h1234);
        // Every coefficient restored to zero by both adjust keys
        for (i = 1; i <= NUM_COEF; i++) begin
            v = 16'($urandom) | 16'h0001;
            wr_reg(REG_COEF0 + 4'(i - 1), v);
            wr_reg(REG_SEL, 16'(i));
            press(1'b1, 1'b0, 1'b0);
            rd_reg(REG_COEF0 + 4'(i - 1), 16'h0000);
        end
        wr_reg(REG_CTRL, 16'h002E);
        wr_reg(REG_SEL, {12'h000, SEL_SHAPE});
        press(1'b1, 1'b0, 1'b0);
        rd_reg(REG_CTRL, 16'h0026);
        // Phase alone: flat white at plus quarter, black at minus quarter, each shape
        for (i = 0; i < 3; i++) begin
            amp = AMP_W'($urandom % 32'h0000063D);
            wr_reg(REG_AMP, {5'h00, amp});
            wr_reg(REG_CTRL, 16'h0026 | 16'(i << CTRL_SHAPE_LSB));
            wr_reg(REG_COEF0 + 4'(C_PHASE), 16'h4000);
            line(8, 1'b1, amp, amp);
            wr_reg(REG_COEF0 + 4'(C_PHASE), 16'hC000);
            line(8, 1'b1, 11'h000, 11'h000);
        end
        // Clamped horizontal frequency: half a cycle per sample alternates white and black
        wr_reg(REG_CTRL, 16'h0026);
        wr_reg(REG_COEF0 + 4'(C_PHASE), 16'h4000);
        wr_reg(REG_COEF0 + 4'(C_HORIZ_FREQ), 16'h7FFF);
        line(8, 1'b1, amp, 11'h000);
        wr_reg(REG_COEF0 + 4'(C_HORIZ_FREQ), 16'h8001);
        line(8, 1'b1, amp, 11'h000);
        // Temporal growth past the maximum folds and flags; software clears the flags
        wr_reg(REG_FRAME_DT, 16'hFFFF);
        wr_reg(REG_COEF0 + 4'(C_TIME_CHANGE_HORIZ), 16'h7FFF);
        wr_reg(REG_COEF0 + 4'(C_TIME_CHANGE_VERT), 16'h7FFF);
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        rd_reg(REG_STATUS, 16'h000C);
        wr_reg(REG_STATUS, 16'h000C);
        rd_reg(REG_STATUS, 16'h0000);
        // Output disabled: no samples reach the monitor
        wr_reg(REG_CTRL, 16'h0006);
        cnt0 = mon_count;
        line(8, 1'b0, 11'h000, 11'h000);
        repeat (4) @(posedge clk);
        check(mon_count, cnt0);
        end_sim();
    end
endmodule

// >>> testbench/zpg_wave_monitor.sv
// Waveform monitor model that captures each output sample of the generator
module zpg_wave_monitor import zpg_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Incoming video level
    input wire logic [AMP_W-1:0] i_level,
    input wire logic i_valid,
    // Captured sample
    output logic [AMP_W-1:0] o_sample,
    output logic o_stb,
    output logic [15:0] o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latch each valid sample and count them, like a scope trigger would
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sample <= 11'h000;
            o_stb <= 1'b0;
            o_count <= 16'h0000;
        end else begin
            o_stb <= i_valid;
            if (i_valid) begin
                o_sample <= i_level;
                o_count <= o_count + 16'h0001;
            end
        end
    end
endmodule
